// file: common/fwsb_pkg.sv
package fwsb_pkg;

	// ------------------------------------------------------------
	// status bit positions on the flash data bus
	// ------------------------------------------------------------
	localparam int POLL_POS    = 7;
	localparam int TOG1_POS    = 6;
	localparam int TMO_POS     = 5;
	localparam int WIN_POS     = 3;
	localparam int TOG2_POS    = 2;

	// ------------------------------------------------------------
	// bus widths and timing
	// ------------------------------------------------------------
	localparam int ADDR_W      = 22;
	localparam int DATA_W      = 16;
	localparam int CLK_MHZ     = 200;
	// read strobe width in ns, least time, rounded up
	localparam int RD_NS       = 70;
	localparam int RD_CYC      = (RD_NS * CLK_MHZ + 999) / 1000;
	// write pulse width in ns, least time, rounded up
	localparam int WR_NS       = 50;
	localparam int WR_CYC      = (WR_NS * CLK_MHZ + 999) / 1000;
	// sector erase window in us
	localparam int WIN_US      = 50;
	localparam int WIN_CYC     = WIN_US * CLK_MHZ;
	localparam int CNT_W       = 16;

	// ------------------------------------------------------------
	// command words
	// ------------------------------------------------------------
	localparam logic [15:0] CMD_RESET  = 16'h00F0;
	localparam logic [15:0] CMD_ERASE  = 16'h0030;

	// ------------------------------------------------------------
	// user operations and answers
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		FWSB_OP_READ   = 3'h0,
		FWSB_OP_WRITE  = 3'h1,
		FWSB_OP_POLL   = 3'h2,
		FWSB_OP_SERASE = 3'h3,
		FWSB_OP_RESET  = 3'h4
	} fwsb_op_type;

	typedef struct packed
	{
		fwsb_op_type             op;
		logic [ADDR_W-1:0]       addr;
		logic [DATA_W-1:0]       data;
	} fwsb_req_type;

	typedef struct packed
	{
		logic [DATA_W-1:0]       data;
		logic                    done;     // operation finished well
		logic                    fail;     // timing limit exceeded
		logic                    late;     // added erase may be lost
	} fwsb_rsp_type;

endpackage

// file: src/fwsb_cycle.sv
`timescale 1ns/1ps
`default_nettype none

// one flash bus cycle: strobe held for a fixed count, data sampled at end
module fwsb_cycle
	import fwsb_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              go_i,
	input  wire logic              wr_i,
	input  wire logic [DATA_W-1:0] dq_in_i,
	output logic                   ce_n_o,
	output logic                   oe_n_o,
	output logic                   we_n_o,
	output logic                   dq_oe_n_o,
	output logic [DATA_W-1:0]      rdata_o,
	output logic                   busy_o,
	output logic                   done_o
);

	logic [7:0]        cnt_r, cnt_nxt;
	logic              act_r, act_nxt;
	logic              wr_r,  wr_nxt;
	logic              done_r, done_nxt;
	logic [DATA_W-1:0] rd_r,  rd_nxt;

	// ------------------------------------------------------------
	// next state; read data is caught on the last strobe cycle
	// ------------------------------------------------------------
	always_comb
	begin
		cnt_nxt  = cnt_r;
		act_nxt  = act_r;
		wr_nxt   = wr_r;
		rd_nxt   = rd_r;
		done_nxt = 1'b0;
		if (!act_r && go_i)
		begin
			act_nxt = 1'b1;
			wr_nxt  = wr_i;
			cnt_nxt = wr_i ? 8'(WR_CYC) : 8'(RD_CYC);
		end
		else if (act_r)
		begin
			if (cnt_r == 8'h01)
			begin
				act_nxt  = 1'b0;
				done_nxt = 1'b1;
				if (!wr_r)
					rd_nxt = dq_in_i;
			end
			cnt_nxt = cnt_r - 8'h01;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_r  <= 8'h00;
			act_r  <= 1'b0;
			wr_r   <= 1'b0;
			done_r <= 1'b0;
			rd_r   <= 16'h0000;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			act_r  <= act_nxt;
			wr_r   <= wr_nxt;
			done_r <= done_nxt;
			rd_r   <= rd_nxt;
		end
	end

	// strobes are decoded from act_r and wr_r; only ce_n_o comes straight from a register
	assign ce_n_o    = !act_r;
	assign oe_n_o    = !(act_r && !wr_r);
	assign we_n_o    = !(act_r && wr_r);
	assign dq_oe_n_o = !(act_r && wr_r);
	assign rdata_o   = rd_r;
	assign busy_o    = act_r;
	assign done_o    = done_r;

endmodule

`default_nettype wire

// file: src/fwsb_host.sv
// Operation
// - after timeout issue reset command; the host only reports fail, the user then sends FWSB_OP_RESET
// - fast added erases may skip window check
// - confirm acceptance, check window around commands
// - window high afterwards: command maybe lost
// - status reads need a valid address
`timescale 1ns/1ps
`default_nettype none

module fwsb_host
	import fwsb_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              nrst_i,
	// user side
	input  wire logic              req_valid_i,
	input  wire fwsb_req_type      req_i,
	output logic                   req_ready_o,
	output logic                   rsp_valid_o,
	output fwsb_rsp_type           rsp_o,
	// flash pins
	output logic [ADDR_W-1:0]      flash_addr_o,
	output logic [DATA_W-1:0]      flash_dq_o,
	input  wire logic [DATA_W-1:0] flash_dq_i,
	output logic                   flash_dq_oe_n_o,
	output logic                   flash_ce_n_o,
	output logic                   flash_oe_n_o,
	output logic                   flash_we_n_o,
	input  wire logic              ready_busy_output_i
);

	// ------------------------------------------------------------
	// reset release and pin synchroniser
	// ------------------------------------------------------------
	logic       rst_a_r, rst_n;
	logic [2:0] rb_sync_r;
	logic       rb_r;

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_a_r <= 1'b0;
			rst_n   <= 1'b0;
		end
		else
		begin
			rst_a_r <= 1'b1;
			rst_n   <= rst_a_r;
		end
	end

	// busy pin changes count once stages two and three agree
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rb_sync_r <= 3'b111;
			rb_r      <= 1'b1;
		end
		else
		begin
			rb_sync_r <= {rb_sync_r[1:0], ready_busy_output_i};
			if (rb_sync_r[1] == rb_sync_r[2])
				rb_r <= rb_sync_r[2];
		end
	end

	// ------------------------------------------------------------
	// state machine
	// ------------------------------------------------------------
	typedef enum logic [6:0]
	{
		ST_IDLE  = 7'b000_0001,
		ST_CYC   = 7'b000_0010,
		ST_POLLA = 7'b000_0100,
		ST_POLLB = 7'b000_1000,
		ST_PRE   = 7'b001_0000,
		ST_POST  = 7'b010_0000,
		ST_RSP   = 7'b100_0000
	} fwsb_st_type;

	fwsb_st_type       st_r, st_nxt;
	fwsb_req_type      cur_r, cur_nxt;
	fwsb_rsp_type      rsp_r, rsp_nxt;
	logic [DATA_W-1:0] first_r, first_nxt;
	logic              win_open_r, win_open_nxt;
	logic              go, go_wr, cyc_busy, cyc_done;
	logic [DATA_W-1:0] cyc_rdata;
	logic [DATA_W-1:0] wdata;

	fwsb_cycle u_cycle
	(
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n),
		.go_i      (go),
		.wr_i      (go_wr),
		.dq_in_i   (flash_dq_i),
		.ce_n_o    (flash_ce_n_o),
		.oe_n_o    (flash_oe_n_o),
		.we_n_o    (flash_we_n_o),
		.dq_oe_n_o (flash_dq_oe_n_o),
		.rdata_o   (cyc_rdata),
		.busy_o    (cyc_busy),
		.done_o    (cyc_done)
	);

	// toggle check: bit changed between two reads
	function automatic logic toggled(input logic [DATA_W-1:0] a,
		input logic [DATA_W-1:0] b, input int pos);
		toggled = a[pos] ^ b[pos];
	endfunction

	// next state; the address of the request stays on the pins
	// throughout so status is read from a valid busy-bank address
	always_comb
	begin
		st_nxt       = st_r;
		cur_nxt      = cur_r;
		rsp_nxt      = rsp_r;
		first_nxt    = first_r;
		win_open_nxt = win_open_r;
		go           = 1'b0;
		go_wr        = 1'b0;
		wdata        = cur_r.data;
		case (st_r)
			ST_IDLE:
			begin
				if (req_valid_i)
				begin
					cur_nxt = req_i;
					rsp_nxt = '0;
					case (req_i.op)
						FWSB_OP_WRITE:  st_nxt = ST_CYC;
						FWSB_OP_READ:   st_nxt = ST_CYC;
						FWSB_OP_RESET:  st_nxt = ST_CYC;
						FWSB_OP_POLL:   st_nxt = ST_POLLA;
						FWSB_OP_SERASE: st_nxt = ST_PRE;
						default:        st_nxt = ST_RSP;
					endcase
				end
			end
			ST_CYC:
			begin
				go    = !cyc_busy && !cyc_done;
				go_wr = cur_r.op != FWSB_OP_READ;
				if (cur_r.op == FWSB_OP_RESET)
					wdata = CMD_RESET;
				if (cyc_done)
				begin
					rsp_nxt.data = cyc_rdata;
					rsp_nxt.done = 1'b1;
					// sector erase still owes its second window check
					if (cur_r.op == FWSB_OP_SERASE)
						st_nxt = ST_POST;
					else
						st_nxt = ST_RSP;
				end
			end
			ST_POLLA:
			begin
				go = !cyc_busy && !cyc_done;
				if (cyc_done)
				begin
					first_nxt = cyc_rdata;
					st_nxt    = ST_POLLB;
				end
			end
			ST_POLLB:
			begin
				go = !cyc_busy && !cyc_done;
				if (cyc_done)
				begin
					rsp_nxt.data = cyc_rdata;
					if (!toggled(first_r, cyc_rdata, TOG1_POS))
					begin
						rsp_nxt.done = 1'b1;
						st_nxt       = ST_RSP;
					end
					else if (cyc_rdata[TMO_POS])
					begin
						first_nxt = cyc_rdata;
						if (first_r[TMO_POS])
						begin
							rsp_nxt.fail = 1'b1;
							st_nxt       = ST_RSP;
						end
					end
					else
						first_nxt = cyc_rdata;
				end
			end
			ST_PRE:
			begin
				go = !cyc_busy && !cyc_done;
				if (cyc_done)
				begin
					win_open_nxt = !cyc_rdata[WIN_POS] && !rb_r;
					if (cyc_rdata[WIN_POS] && !rb_r)
					begin
						rsp_nxt.late = 1'b1;
						st_nxt       = ST_RSP;
					end
					else
						st_nxt = ST_CYC;
					cur_nxt.data = CMD_ERASE;
				end
			end
			ST_POST:
			begin
				go = !cyc_busy && !cyc_done;
				if (cyc_done)
				begin
					rsp_nxt.data = cyc_rdata;
					if (win_open_r && cyc_rdata[WIN_POS])
						rsp_nxt.late = 1'b1;
					st_nxt = ST_RSP;
				end
			end
			ST_RSP:
			begin
				st_nxt = ST_IDLE;
			end
			default:
				st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r       <= ST_IDLE;
			cur_r      <= '0;
			rsp_r      <= '0;
			first_r    <= 16'h0000;
			win_open_r <= 1'b0;
		end
		else
		begin
			st_r       <= st_nxt;
			cur_r      <= cur_nxt;
			rsp_r      <= rsp_nxt;
			first_r    <= first_nxt;
			win_open_r <= win_open_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign req_ready_o  = st_r == ST_IDLE;
	assign rsp_valid_o  = st_r == ST_RSP;
	assign rsp_o        = rsp_r;
	assign flash_addr_o = cur_r.addr;
	assign flash_dq_o   = wdata;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_fail_needs_tmo: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n) rsp_valid_o && rsp_o.fail
		|-> rsp_o.data[TMO_POS])
		else $error("fail reported without timeout bit");

	a_reset_word: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n) (st_r == ST_CYC && cur_r.op == FWSB_OP_RESET
		&& !flash_we_n_o) |-> flash_dq_o == CMD_RESET)
		else $error("reset cycle drove wrong word");

	a_addr_hold: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n) !flash_ce_n_o && $past(!flash_ce_n_o)
		|-> $stable(flash_addr_o))
		else $error("address moved during a cycle");

	a_rsp_one: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n) rsp_valid_o |=> !rsp_valid_o)
		else $error("answer held too long");

	a_done_after: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n) st_r == ST_POLLB && cyc_done
		&& !toggled(first_r, cyc_rdata, TOG1_POS) |=> rsp_valid_o)
		else $error("poll finished without answer");

	a_strobe_excl: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n) !(!flash_oe_n_o && !flash_we_n_o))
		else $error("read and write strobes together");

	a_drive_write: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n) !flash_we_n_o |-> !flash_dq_oe_n_o)
		else $error("write without data drive");

	a_ready_idle: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n) rsp_valid_o |=> req_ready_o)
		else $error("not idle after answer");

	a_late_post: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n) st_r == ST_POST && cyc_done && win_open_r
		&& cyc_rdata[WIN_POS] |=> rsp_valid_o && rsp_o.late)
		else $error("closed window after erase not flagged");

endmodule

`default_nettype wire

// file: tb/fwsb_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// flash device model: status on reads of the busy bank
// ------------------------------------------------------------
module fwsb_flash_model
	import fwsb_pkg::*;
#(
	parameter int WIN_M  = 10000,
	parameter int PROG_M = 3
)
(
	input  wire logic              ref_clk_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] dq_i,
	input  wire logic              ce_n_i,
	input  wire logic              oe_n_i,
	input  wire logic              we_n_i,
	output logic [DATA_W-1:0]      dq_o,
	output logic                   rb_o,
	output var int                 ers_cnt_o
);
	logic [DATA_W-1:0] mem [16];
	logic [DATA_W-1:0] pdata;
	logic [DATA_W-1:0] val;
	logic [DATA_W-1:0] last;
	logic [3:0]        paddr;
	logic [1:0]        bank;
	logic              prog, ers, bad, tmo, tog1, tog2, rd_on, we_on;
	logic [DATA_W-1:0] wq;
	logic              wq_vld;
	int                cnt, win, seen;

	// erased array, nothing running
	initial
	begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
		{prog, ers, bad, tmo, tog1, tog2} = '0;
		{pdata, last, paddr, bank} = '0;
		{cnt, win, seen, ers_cnt_o} = '0;
		{wq, wq_vld} = '0;
	end

	// write data caught while the pulse is low: the host lets go of
	// the bus in the same step as the strobe rises
	assign #1 we_on = !ce_n_i && !we_n_i;
	always @(posedge ref_clk_i)
		if (!ce_n_i && !we_n_i)
		begin
			wq = dq_i;
			wq_vld = 1'b1;
		end

	// released bus shows the inverse, never a stale copy
	assign #1 rd_on = !ce_n_i && !oe_n_i;
	assign dq_o = rd_on ? val : ~last;
	always @(negedge rd_on) last <= val;
	assign rb_o = !(prog || ers);

	// read data: status word only for the bank at work
	always_comb
	begin
		val = mem[addr_i[3:0]];
		if ((prog || ers) && addr_i[21:20] == bank)
		begin
			val = '0;
			val[POLL_POS] = ers ? 1'b0 : ~pdata[7];
			val[TOG1_POS] = tog1;
			val[TMO_POS]  = tmo;
			val[WIN_POS]  = ers && (win >= WIN_M);
			val[TOG2_POS] = tog2;
		end
	end

	// end of each status read advances the engine
	always @(negedge rd_on)
		if ((prog || ers) && addr_i[21:20] == bank)
		begin
			tog1 <= ~tog1;
			tog2 <= ers ? ~tog2 : tog2;
			cnt = cnt + 1;
			if (prog && bad && cnt >= 2)
				tmo <= 1'b1;
			if (prog && !bad && cnt == PROG_M)
			begin
				prog <= 1'b0;
				mem[paddr] <= mem[paddr] & pdata;
			end
		end

	// command decode at the end of each write pulse
	always @(negedge we_on)
		if (wq_vld)
		begin
			wq_vld = 1'b0;
			if (ers && win >= WIN_M)
				cnt = cnt;
			else if (wq == CMD_RESET && tmo)
				{prog, tmo} <= 2'b00;
			else if (wq == CMD_ERASE && !prog)
			begin
				ers <= 1'b1;
				bank <= addr_i[21:20];
				ers_cnt_o <= ers_cnt_o + 1;
			end
			else if (!prog && !ers)
			begin
				tmo <= 1'b0;
				cnt = 0;
				prog <= 1'b1;
				bank <= addr_i[21:20];
				paddr <= addr_i[3:0];
				pdata <= wq;
				bad <= |(wq & ~mem[addr_i[3:0]]);
			end
		end

	// acceptance window counted in clock cycles
	always @(posedge ref_clk_i)
		if (ers_cnt_o != seen)
			{seen, win} <= {ers_cnt_o, 32'h0000_0000};
		else if (win < WIN_M)
			win <= win + 1;
endmodule
`default_nettype wire

// file: tb/flash_write_status_bits_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
	begin \
		tests_run++; \
		if ((g) !== (e)) \
		begin \
			failures++; \
			$display("[ERR] %0t got %0h want %0h", $time, g, e); \
		end \
	end

module flash_write_status_bits_tb;
	import fwsb_pkg::*;
	localparam logic [ADDR_W-1:0] ADR_A = 22'h00_0003;
	localparam logic [ADDR_W-1:0] ADR_B = 22'h10_0003;
	localparam logic [ADDR_W-1:0] ADR_E = 22'h20_0005;
	logic              ref_clk_i, nrst_i, req_valid, req_ready, rsp_valid;
	logic              dq_oe_n, ce_n, oe_n, we_n, rb;
	fwsb_req_type      req;
	fwsb_rsp_type      rsp, got;
	logic [ADDR_W-1:0] fa;
	logic [DATA_W-1:0] hdq, mdq, dq_bus, r1, r2;
	int                failures, tests_run, cyc, ecmds;

	// host drives dq only while its enable is low
	assign dq_bus = !dq_oe_n ? hdq : mdq;

	fwsb_host dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready),
		.rsp_valid_o(rsp_valid), .rsp_o(rsp), .flash_addr_o(fa),
		.flash_dq_o(hdq), .flash_dq_i(dq_bus), .flash_dq_oe_n_o(dq_oe_n),
		.flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
		.ready_busy_output_i(rb));

	fwsb_flash_model #(.WIN_M(WIN_CYC), .PROG_M(3)) flash (
		.ref_clk_i(ref_clk_i), .addr_i(fa), .dq_i(dq_bus), .ce_n_i(ce_n),
		.oe_n_i(oe_n), .we_n_i(we_n), .dq_o(mdq), .rb_o(rb),
		.ers_cnt_o(ecmds));

	// one request, held until taken, then wait for the answer
	task automatic do_op(input fwsb_op_type op,
		input logic [ADDR_W-1:0] a);
		@(posedge ref_clk_i);
		#1;
		req = '{op, a, 16'h0000};
		req.data = (op == FWSB_OP_WRITE) ? r1 : 16'h0000;
		req_valid = 1'b1;
		do @(posedge ref_clk_i); while (req_ready !== 1'b1);
		#1 req_valid = 1'b0;
		do @(posedge ref_clk_i); while (rsp_valid !== 1'b1);
		got = rsp;
	endtask

	// program, foreign bank read, completion
	task automatic t_program;
		r1 = 16'h1234;
		do_op(FWSB_OP_WRITE, ADR_A);
		do_op(FWSB_OP_READ, ADR_B);
		`CHK(got.data, 16'hFFFF)
		do_op(FWSB_OP_READ, ADR_A);
		`CHK(got.data[7:3], 5'b10000)
		do_op(FWSB_OP_POLL, ADR_A);
		`CHK({got.done, got.fail}, 2'b10)
		do_op(FWSB_OP_READ, ADR_A);
		`CHK(got.data, 16'h1234)
	endtask

	// raising cleared bits must end in a timeout
	task automatic t_fail;
		r1 = 16'h00FF;
		do_op(FWSB_OP_WRITE, ADR_A);
		do_op(FWSB_OP_POLL, ADR_A);
		`CHK({got.done, got.fail}, 2'b01)
		do_op(FWSB_OP_READ, ADR_A);
		`CHK(got.data[TMO_POS], 1'b1)
		do_op(FWSB_OP_RESET, ADR_A);
		do_op(FWSB_OP_READ, ADR_A);
		`CHK(got.data, 16'h1234)
	endtask

	// sector erase: window open, added command, window closed
	task automatic t_erase;
		do_op(FWSB_OP_SERASE, ADR_E);
		`CHK(got.late, 1'b0)
		do_op(FWSB_OP_READ, ADR_E);
		`CHK({got.data[POLL_POS], got.data[WIN_POS]}, 2'b00)
		do_op(FWSB_OP_SERASE, ADR_E);
		`CHK({got.late, ecmds}, {1'b0, 32'd2})
		// window length is fixed by the acceptance time
		repeat (WIN_CYC + 100) @(posedge ref_clk_i);
		do_op(FWSB_OP_READ, ADR_E);
		r2 = got.data;
		`CHK(r2[WIN_POS], 1'b1)
		do_op(FWSB_OP_READ, ADR_E);
		`CHK(got.data[TOG1_POS], ~r2[TOG1_POS])
		do_op(FWSB_OP_SERASE, ADR_E);
		`CHK({got.late, ecmds}, {1'b1, 32'd2})
		do_op(FWSB_OP_RESET, ADR_E);
		do_op(FWSB_OP_READ, ADR_E);
		`CHK(got.data[WIN_POS], 1'b1)
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	// ceiling well above the erase wait plus all operations
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			failures++;
			$display("[ERR] %0t hang cut short", $time);
			give_verdict();
		end
	end

	initial
	begin
		{failures, tests_run, cyc} = '0;
		{nrst_i, req_valid, req, r1, r2} = '0;
		repeat (4) @(posedge ref_clk_i);
		#1 nrst_i = 1'b1;
		repeat (3) @(posedge ref_clk_i);
		t_program();
		t_fail();
		t_erase();
		give_verdict();
	end
endmodule
`default_nettype wire
